// ==== hdl/pc_and_return_stack_unit.sv ====
// program counter, return stack, fast shadow stack and q-phase sequencer
// Function
// - 5-bit pointer 0..31, up on push, down on pop, zero on reset
// - software reads and writes the pointer through its register
// - full flag sets after 31 pushes without a pop
// - full and underflow flags clear only by software or power-on
// - fault reset on: 31st push stores pc+2, flags full, resets
// - fault reset off: pointer reaches 31, later pushes overwrite top
// - pop when empty loads pc zero, sets underflow, pointer stays 0
// - fault always sets flag; device reset only if option enabled
// - register: full bit 7, underflow bit 6, bit 5 zero, pointer 4:0
// - push increments and stores pc; pop decrements, drops top
// - one-level shadow of status, working, bank; restored by fast return
// - both interrupt priorities write the shadow
// - fast call captures shadow for later fast return
// - 21-bit pc; low byte accessible, upper bytes only via latches
// - pc bit 0 fixed zero, sequential fetch adds 2
// - low byte write loads pc upper bytes from latches; read copies upper to latches
// - call, goto, branch write pc without latches
// - clock divided into four phases; pc up in q1, latch in q4
// - call, return, goto or branch flushes prefetch, taking two cycles
// - operand read strobe in q1, destination write strobe in q3
// - absolute targets are word addresses into pc bits 20:1
// - relative offsets count words, scaled by two bytes
// - stack of 31 entries of 21 bits; pointer zero has no storage
// - push increments then writes; return reads then decrements
// - returns leave the holding latches unchanged, except an underflow fault reset clears them
module pc_and_return_stack_unit #(
  parameter int IR_W = 16
) (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire logic                          por,
  input  wire logic [3:0]                    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output      logic [7:0]                    reg_rdata,
  input  wire pc_stack_pkg::core_cmd_t       cmd,
  input  wire logic                          cmd_valid,
  input  wire logic                          irq_vector,
  input  wire pc_stack_pkg::fast_regs_t      live_regs,
  input  wire logic [IR_W-1:0]               fetch_data,
  output      pc_stack_pkg::fast_regs_t      restore_regs,
  output      logic                          restore_load,
  output      logic [pc_stack_pkg::PC_W-1:0] fetch_addr,
  output      logic [IR_W-1:0]               instr_reg,
  output      logic                          instr_valid,
  output      logic [1:0]                    q_phase,
  output      logic                          operand_rd,
  output      logic                          dest_wr,
  output      logic                          stack_reset
);
  localparam int W = pc_stack_pkg::PC_W;

  logic [1:0]   q;
  logic [W-1:0] pc;
  logic [7:0]   lat_hi;
  logic [4:0]   lat_up;
  logic [4:0]   sp;
  logic         full_flag;
  logic         unf_flag;
  logic         fault_rst_en;
  logic [W-1:0] stack_mem [1:pc_stack_pkg::DEPTH];
  logic         flush;
  pc_stack_pkg::fast_regs_t shadow;

  // commands are acted on once per instruction cycle, at q4
  logic exec;
  logic is_push;
  logic is_pop;
  logic full_fault;
  logic unf_fault;
  logic dev_rst;
  logic [W-1:0] push_val;
  logic [W-1:0] top_of_stack;
  logic [W-1:0] ofs_bytes;

  function automatic logic [W-1:0] align(input logic [W-1:0] a);
    align = {a[W-1:1], 1'b0};
  endfunction : align

  assign exec     = cmd_valid && (q == pc_stack_pkg::Q4);
  assign is_push  = exec && (cmd.op == pc_stack_pkg::OP_PUSH ||
                    cmd.op == pc_stack_pkg::OP_CALL);
  assign is_pop   = exec && (cmd.op == pc_stack_pkg::OP_POP ||
                    cmd.op == pc_stack_pkg::OP_RET);
  // full trips on the push that lands on entry 31
  assign full_fault = is_push && (sp >= pc_stack_pkg::SP_MAX - 5'h01);
  assign unf_fault  = is_pop && (sp == pc_stack_pkg::SP_RESET);
  assign dev_rst  = fault_rst_en && (full_fault || unf_fault);
  assign top_of_stack      = (sp == pc_stack_pkg::SP_RESET) ? '0 : stack_mem[sp];
  // pc already points past this instruction, i.e. pc+2 of it
  assign push_val = pc;
  assign ofs_bytes = W'({{(W-12){cmd.offset_words[10]}},
                         cmd.offset_words, 1'b0});

  // four-phase sequencer
  always_ff @(posedge clk) begin
    if (sys_rst || dev_rst) begin
      q <= pc_stack_pkg::Q1;
    end else begin
      q <= q + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stack_reset <= 1'b0;
    end else begin
      stack_reset <= dev_rst;
    end
  end

  // pointer, written by stack ops or by software
  always_ff @(posedge clk) begin
    if (sys_rst || dev_rst) begin
      sp <= pc_stack_pkg::SP_RESET;
    end else if (is_push) begin
      if (sp != pc_stack_pkg::SP_MAX) begin
        sp <= sp + 5'h01;
      end
    end else if (is_pop) begin
      if (sp != pc_stack_pkg::SP_RESET) begin
        sp <= sp - 5'h01;
      end
    end else if (reg_wr && reg_addr == pc_stack_pkg::ADDR_SP) begin
      sp <= reg_wdata[4:0];
    end
  end

  // flags survive fault and ordinary resets; set beats clear
  always_ff @(posedge clk) begin
    if (por) begin
      full_flag <= 1'b0;
      unf_flag  <= 1'b0;
    end else begin
      if (full_fault) begin
        full_flag <= 1'b1;
      end else if (reg_wr && reg_addr == pc_stack_pkg::ADDR_SP &&
                   !reg_wdata[pc_stack_pkg::FULL_BIT]) begin
        full_flag <= 1'b0;
      end
      if (unf_fault) begin
        unf_flag <= 1'b1;
      end else if (reg_wr && reg_addr == pc_stack_pkg::ADDR_SP &&
                   !reg_wdata[pc_stack_pkg::UNF_BIT]) begin
        unf_flag <= 1'b0;
      end
    end
  end

  // option defaults to enabled and survives fault resets
  always_ff @(posedge clk) begin
    if (por) begin
      fault_rst_en <= 1'b1;
    end else if (reg_wr && reg_addr == pc_stack_pkg::ADDR_CFG) begin
      fault_rst_en <= reg_wdata[0];
    end
  end

  // stack storage, index 0 has none
  generate
    for (genvar i = 1; i <= pc_stack_pkg::DEPTH; i++) begin : g_ent
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          stack_mem[i] <= '0;
        end else if (is_push && (sp == pc_stack_pkg::SP_MAX ?
                     i == pc_stack_pkg::DEPTH :
                     i == int'(sp) + 1)) begin
          stack_mem[i] <= push_val;
        end else if (reg_wr && i == int'(sp)) begin
          case (reg_addr)
            pc_stack_pkg::ADDR_TOS_LO: stack_mem[i][7:0]   <= reg_wdata;
            pc_stack_pkg::ADDR_TOS_HI: stack_mem[i][15:8]  <= reg_wdata;
            pc_stack_pkg::ADDR_TOS_UP: stack_mem[i][20:16] <= reg_wdata[4:0];
            default: ;
          endcase
        end
      end
    end
  endgenerate

  // program counter
  always_ff @(posedge clk) begin
    if (sys_rst || dev_rst) begin
      pc <= pc_stack_pkg::PC_RESET;
    end else if (exec && (cmd.op == pc_stack_pkg::OP_CALL ||
                          cmd.op == pc_stack_pkg::OP_GOTO)) begin
      pc <= {cmd.target_word, 1'b0};
    end else if (exec && cmd.op == pc_stack_pkg::OP_BRANCH) begin
      pc <= align(pc + ofs_bytes);
    end else if (exec && (cmd.op == pc_stack_pkg::OP_RET || unf_fault)) begin
      // any pop from an empty stack sends the pc to zero
      pc <= unf_fault ? pc_stack_pkg::PC_RESET : align(top_of_stack);
    end else if (reg_wr && reg_addr == pc_stack_pkg::ADDR_PC_LO) begin
      pc <= align({lat_up, lat_hi, reg_wdata});
    end else if (q == pc_stack_pkg::Q1) begin
      pc <= pc + pc_stack_pkg::PC_STEP;
    end
  end

  // holding latches, returns only clear them through an underflow fault reset
  always_ff @(posedge clk) begin
    if (sys_rst || dev_rst) begin
      lat_hi <= 8'h00;
      lat_up <= 5'h00;
    end else if (reg_rd && reg_addr == pc_stack_pkg::ADDR_PC_LO) begin
      lat_hi <= pc[15:8];
      lat_up <= pc[20:16];
    end else if (reg_wr && reg_addr == pc_stack_pkg::ADDR_LAT_HI) begin
      lat_hi <= reg_wdata;
    end else if (reg_wr && reg_addr == pc_stack_pkg::ADDR_LAT_UP) begin
      lat_up <= reg_wdata[4:0];
    end
  end

  // fetch and pipeline; a call, return, goto or branch discards the prefetched word
  always_ff @(posedge clk) begin
    if (sys_rst || dev_rst) begin
      flush <= 1'b1;
    end else if (exec && cmd.op != pc_stack_pkg::OP_NONE &&
                 cmd.op != pc_stack_pkg::OP_PUSH &&
                 cmd.op != pc_stack_pkg::OP_POP) begin
      flush <= 1'b1;
    end else if (q == pc_stack_pkg::Q4) begin
      flush <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || dev_rst) begin
      instr_reg   <= '0;
      instr_valid <= 1'b0;
    end else if (q == pc_stack_pkg::Q4) begin
      instr_reg   <= fetch_data;
      instr_valid <= !flush && !(exec && cmd.op != pc_stack_pkg::OP_NONE &&
                     cmd.op != pc_stack_pkg::OP_PUSH &&
                     cmd.op != pc_stack_pkg::OP_POP);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fetch_addr <= pc_stack_pkg::PC_RESET;
      q_phase    <= pc_stack_pkg::Q1;
      operand_rd <= 1'b0;
      dest_wr    <= 1'b0;
    end else begin
      fetch_addr <= pc;
      q_phase    <= q;
      operand_rd <= (q == pc_stack_pkg::Q1);
      dest_wr    <= (q == pc_stack_pkg::Q3);
    end
  end

  // fast shadow stack, single level and not on the register port
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shadow <= '0;
    end else if (irq_vector || (exec && cmd.fast &&
                 cmd.op == pc_stack_pkg::OP_CALL)) begin
      shadow <= live_regs;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      restore_regs <= '0;
      restore_load <= 1'b0;
    end else begin
      restore_regs <= shadow;
      restore_load <= exec && cmd.fast &&
                      cmd.op == pc_stack_pkg::OP_RET;
    end
  end

  // register read port, data one cycle after strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= pc_stack_pkg::RETURN_STACK_POINTER_RESET;
    end else if (reg_rd) begin
      case (reg_addr)
        pc_stack_pkg::ADDR_SP:
          reg_rdata <= {full_flag, unf_flag, 1'b0, sp};
        pc_stack_pkg::ADDR_TOS_LO: reg_rdata <= top_of_stack[7:0];
        pc_stack_pkg::ADDR_TOS_HI: reg_rdata <= top_of_stack[15:8];
        pc_stack_pkg::ADDR_TOS_UP: reg_rdata <= {3'h0, top_of_stack[20:16]};
        pc_stack_pkg::ADDR_PC_LO:  reg_rdata <= pc[7:0];
        pc_stack_pkg::ADDR_LAT_HI: reg_rdata <= lat_hi;
        pc_stack_pkg::ADDR_LAT_UP: reg_rdata <= {3'h0, lat_up};
        pc_stack_pkg::ADDR_CFG:    reg_rdata <= {7'h00, fault_rst_en};
        default:                   reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  sp_range_a: assert property (@(posedge clk) disable iff (sys_rst)
    sp <= pc_stack_pkg::SP_MAX) else $error("pointer out of range");
  push_inc_a: assert property (@(posedge clk) disable iff (sys_rst)
    is_push && !dev_rst && sp < 5'h1e |=> sp == $past(sp) + 5'h01)
    else $error("push did not increment");
  full_set_a: assert property (@(posedge clk) disable iff (por)
    full_fault |=> full_flag) else $error("full flag not set");
  unf_pc_a: assert property (@(posedge clk) disable iff (sys_rst)
    unf_fault && !fault_rst_en |=> pc == '0 && sp == '0 && unf_flag)
    else $error("underflow handling wrong");
  fault_rst_a: assert property (@(posedge clk) disable iff (sys_rst)
    full_fault && fault_rst_en |=> stack_reset && sp == '0)
    else $error("fault reset missing");
  no_fault_rst_a: assert property (@(posedge clk) disable iff (sys_rst)
    !fault_rst_en |=> !stack_reset) else $error("unexpected reset");
  pc_even_a: assert property (@(posedge clk) disable iff (sys_rst)
    pc[0] == 1'b0) else $error("pc odd");
  ret_latch_a: assert property (@(posedge clk) disable iff (sys_rst)
    exec && cmd.op == pc_stack_pkg::OP_RET && !reg_wr && !reg_rd
    |=> $stable(lat_hi) && $stable(lat_up))
    else $error("return moved latches");
  bit5_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    reg_rd && reg_addr == pc_stack_pkg::ADDR_SP |=> reg_rdata[5] == 1'b0)
    else $error("bit 5 not zero");
endmodule : pc_and_return_stack_unit

// ==== hdl/pc_stack_pkg.sv ====
// shared constants and types for the program counter and return stack unit
package pc_stack_pkg;
  localparam int PC_W      = 21;
  localparam int SP_W      = 5;
  localparam int DEPTH     = 31;
  localparam logic [SP_W-1:0] SP_MAX   = 5'h1f;
  localparam logic [SP_W-1:0] SP_RESET = 5'h00;
  localparam int FULL_BIT  = 7;
  localparam int UNF_BIT   = 6;
  localparam int ZERO_BIT  = 5;
  localparam logic [7:0] RETURN_STACK_POINTER_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [PC_W-1:0] PC_STEP  = 21'h000002;
  // register addresses on the plain register port
  localparam logic [3:0] ADDR_SP      = 4'h0;
  localparam logic [3:0] ADDR_TOS_LO  = 4'h1;
  localparam logic [3:0] ADDR_TOS_HI  = 4'h2;
  localparam logic [3:0] ADDR_TOS_UP  = 4'h3;
  localparam logic [3:0] ADDR_PC_LO   = 4'h4;
  localparam logic [3:0] ADDR_LAT_HI  = 4'h5;
  localparam logic [3:0] ADDR_LAT_UP  = 4'h6;
  localparam logic [3:0] ADDR_CFG     = 4'h7;
  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q2 = 2'h1;
  localparam logic [1:0] Q3 = 2'h2;
  localparam logic [1:0] Q4 = 2'h3;

  typedef enum logic [2:0] {
    OP_NONE, OP_PUSH, OP_POP, OP_CALL, OP_RET, OP_GOTO, OP_BRANCH
  } op_t;

  typedef struct packed {
    op_t              op;
    logic             fast;
    logic [PC_W-2:0]  target_word;
    logic [10:0]      offset_words;
  } core_cmd_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] working;
    logic [7:0] bank;
  } fast_regs_t;
endpackage : pc_stack_pkg

// ==== bench/prog_mem_model.sv ====
// program memory model answering instruction fetches
module prog_mem_model #(
  parameter int IR_W = 16
) (
  input  wire logic [pc_stack_pkg::PC_W-1:0] fetch_addr,
  output      logic [IR_W-1:0]               fetch_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // word pattern differs per address so a stale fetch shows up
  assign fetch_data = IR_W'(fetch_addr[20:1]) ^ IR_W'(16'h5a3c);
endmodule : prog_mem_model

// ==== bench/pc_and_return_stack_unit_tb.sv ====
// self-checking bench for the program counter and return stack unit
module pc_and_return_stack_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, por, reg_wr, reg_rd, cmd_valid, irq_vector;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rnd;
  logic [15:0] fetch_data, instr_reg;
  logic [20:0] fetch_addr;
  logic [1:0]  q_phase;
  logic        restore_load, instr_valid, operand_rd, dest_wr, stack_reset;
  logic        rd_d = 1'b0;
  logic [8:0]  e;
  pc_stack_pkg::core_cmd_t  cmd;
  pc_stack_pkg::fast_regs_t live_regs, restore_regs, fe;
  pc_stack_pkg::fast_regs_t rq[$];
  logic [8:0]  eq[$];
  int          n_mismatch, checked, n_sreset;

  pc_and_return_stack_unit #(.IR_W(16)) u_pc_and_return_stack_unit (
    .clk(clk), .sys_rst(sys_rst), .por(por), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cmd(cmd), .cmd_valid(cmd_valid),
    .irq_vector(irq_vector), .live_regs(live_regs),
    .fetch_data(fetch_data), .restore_regs(restore_regs),
    .restore_load(restore_load), .fetch_addr(fetch_addr),
    .instr_reg(instr_reg), .instr_valid(instr_valid), .q_phase(q_phase),
    .operand_rd(operand_rd), .dest_wr(dest_wr), .stack_reset(stack_reset));
  prog_mem_model #(.IR_W(16)) u_prog_mem_model (
    .fetch_addr(fetch_addr), .fetch_data(fetch_data));

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  task automatic check(input string nm, input logic [23:0] ex, got);
    checked++;
    if (got !== ex) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask : check

  task automatic finish_test();
    if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // chk low: read only for its side effect on the holding latches
  task automatic rd(input logic [3:0] a, input logic chk, input logic [7:0] x);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    eq.push_back({chk, x});
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd

  // valid held a whole instruction cycle so exactly one q4 takes it
  task automatic issue(input pc_stack_pkg::op_t op, input logic f,
                       input logic [19:0] tw, input logic [10:0] ow);
    @(posedge clk);
    cmd <= '{op: op, fast: f, target_word: tw, offset_words: ow};
    cmd_valid <= 1'b1;
    repeat (4) @(posedge clk);
    cmd_valid <= 1'b0;
  endtask : issue

  task automatic irq(input pc_stack_pkg::fast_regs_t v);
    @(posedge clk);
    live_regs <= v; irq_vector <= 1'b1;
    @(posedge clk);
    irq_vector <= 1'b0;
  endtask : irq

  task automatic pushes(input int n);
    repeat (n) issue(pc_stack_pkg::OP_PUSH, 1'b0, 20'h0, 11'h0);
  endtask : pushes

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (rd_d) begin
      e = eq.pop_front();
      if (e[8]) check("reg_rdata", {16'h0, e[7:0]}, {16'h0, reg_rdata});
    end
    rd_d <= reg_rd;
    if (restore_load) begin
      fe = rq.pop_front();
      check("restore_regs", fe, restore_regs);
    end
    if (stack_reset) n_sreset++;
    if (operand_rd) check("operand_rd_phase", 24'(pc_stack_pkg::Q1), 24'(q_phase));
    if (dest_wr) check("dest_wr_phase", 24'(pc_stack_pkg::Q3), 24'(q_phase));
    if (!sys_rst) check("fetch_addr_bit0", 24'h0, {23'h0, fetch_addr[0]});
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end

  initial begin
    sys_rst = 1'b1; por = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = 4'h0; reg_wdata = 8'h00; cmd = '0; cmd_valid = 1'b0;
    irq_vector = 1'b0; live_regs = '0; rnd = 8'h09;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0; por <= 1'b0;
    rd(pc_stack_pkg::ADDR_SP, 1'b1, 8'h00);
    rd(4'h9, 1'b1, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr_next(rnd);
      wr(pc_stack_pkg::ADDR_SP, rnd);
      rd(pc_stack_pkg::ADDR_SP, 1'b1, {3'h0, rnd[4:0]});
    end
    wr(pc_stack_pkg::ADDR_SP, 8'h00);
    wr(pc_stack_pkg::ADDR_CFG, 8'h00);
    pushes(31);
    rd(pc_stack_pkg::ADDR_SP, 1'b1, 8'h9f);
    pushes(1);
    rd(pc_stack_pkg::ADDR_SP, 1'b1, 8'h9f);
    wr(pc_stack_pkg::ADDR_SP, 8'h00);
    rd(pc_stack_pkg::ADDR_SP, 1'b1, 8'h00);
    issue(pc_stack_pkg::OP_POP, 1'b0, 20'h0, 11'h0);
    rd(pc_stack_pkg::ADDR_SP, 1'b1, 8'h40);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(pc_stack_pkg::ADDR_SP, 1'b1, 8'h40);
    check("stack_reset_count", 24'h0, 24'(n_sreset));
    wr(pc_stack_pkg::ADDR_SP, 8'h00);
    wr(pc_stack_pkg::ADDR_CFG, 8'h01);
    pushes(31);
    repeat (2) @(posedge clk);
    rd(pc_stack_pkg::ADDR_SP, 1'b1, 8'h80);
    check("stack_reset_count", 24'h1, 24'(n_sreset));
    wr(pc_stack_pkg::ADDR_LAT_HI, 8'h34);
    wr(pc_stack_pkg::ADDR_LAT_UP, 8'h12);
    wr(pc_stack_pkg::ADDR_PC_LO, 8'h10);
    wr(pc_stack_pkg::ADDR_LAT_HI, 8'h00);
    wr(pc_stack_pkg::ADDR_LAT_UP, 8'h00);
    rd(pc_stack_pkg::ADDR_PC_LO, 1'b0, 8'h00);
    rd(pc_stack_pkg::ADDR_LAT_HI, 1'b1, 8'h34);
    rd(pc_stack_pkg::ADDR_LAT_UP, 1'b1, 8'h12);
    // goto word 0a1a00 lands on byte 143400; latches must not be used
    issue(pc_stack_pkg::OP_GOTO, 1'b0, 20'ha1a00, 11'h0);
    rd(pc_stack_pkg::ADDR_PC_LO, 1'b0, 8'h00);
    rd(pc_stack_pkg::ADDR_LAT_HI, 1'b1, 8'h34);
    rd(pc_stack_pkg::ADDR_LAT_UP, 1'b1, 8'h14);
    issue(pc_stack_pkg::OP_BRANCH, 1'b0, 20'h0, 11'h100);
    rd(pc_stack_pkg::ADDR_PC_LO, 1'b0, 8'h00);
    rd(pc_stack_pkg::ADDR_LAT_HI, 1'b1, 8'h36);
    issue(pc_stack_pkg::OP_BRANCH, 1'b0, 20'h0, 11'h700);
    rd(pc_stack_pkg::ADDR_PC_LO, 1'b0, 8'h00);
    rd(pc_stack_pkg::ADDR_LAT_HI, 1'b1, 8'h34);
    pushes(1);
    rnd = lfsr_next(rnd);
    irq({rnd, 8'h11, 8'h22});
    rnd = lfsr_next(rnd);
    irq({8'h33, rnd, 8'h44});
    rq.push_back({8'h33, rnd, 8'h44});
    issue(pc_stack_pkg::OP_RET, 1'b1, 20'h0, 11'h0);
    @(posedge clk);
    live_regs <= {8'h55, 8'h66, rnd};
    rq.push_back({8'h55, 8'h66, rnd});
    issue(pc_stack_pkg::OP_CALL, 1'b1, 20'ha1b00, 11'h0);
    issue(pc_stack_pkg::OP_RET, 1'b1, 20'h0, 11'h0);
    rd(pc_stack_pkg::ADDR_LAT_HI, 1'b1, 8'h34);
    rd(pc_stack_pkg::ADDR_LAT_UP, 1'b1, 8'h14);
    rd(pc_stack_pkg::ADDR_SP, 1'b1, 8'h80);
    repeat (4) @(posedge clk);
    check("pending_results", 24'h0, 24'(eq.size() + rq.size()));
    finish_test();
  end
endmodule : pc_and_return_stack_unit_tb
